// ===== design/dhcp_host_port.sv
// Host command and control port of the drive interface
//
// Operation
// - Supported command write sets busy at once and withdraws any pending interrupt.
// - Unsupported opcodes written to the command register are aborted.
// - 20h-23h decode as sector reads, normal or long, with or without retries.
// - 30h-33h decode as sector writes, normal or long, with or without retries.
// - C4h, C5h, E4h, E8h, 3Ch, 40h and 41h decode as multiple, buffer, verify.
// - C8h/C9h decode as DMA read, CAh/CBh as DMA write.
// - EFh, C6h, F8h, F9h decode as mode set and check commands.
// - Any 7xh is seek; 50h is format track; 90h is diagnostic.
// - Standby and idle opcodes stop or start spindle and keep or reload timeout.
// - 3F6h reads alternate status, writes device control; 3F7h reads input only.
// - Alternate status mirrors status and never clears a pending interrupt.
// - Soft reset bit holds the drive in reset until cleared.
// - Disable bit 0 drives the interrupt out; 1 tri-states it.
// - Pending interrupt appears when disable clears; disable powers up 0.
// - Bit 7 of host data is not driven on digital input read.
// - Digital input shows write gate, inverted head number, drive selects low.
// - Any reset reinitialises task file registers, sets busy until init ends, no interrupt.
// - After reset error, count, number read 1; cylinders and drive/head 0.
// - Each data transfer is requested by the interrupt, gated by disable.
// - Pending interrupt clears on status read, supported command write or reset.
// - While busy, parameter register reads return status.
`timescale 1ns/1ps
`include "dhcp_regs.svh"
module dhcp_host_port #(
   parameter int INIT_CYCLES = `DHCP_INIT_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Hardware reset from the host cable
   input wire logic host_reset_n,
   // Task file access
   input wire logic tf_cs,
   input wire logic [2:0] tf_addr,
   input wire logic tf_rd,
   input wire logic tf_wr,
   // Control port access
   input wire logic ctl_cs,
   input wire logic [9:0] ctl_addr,
   input wire logic ctl_rd,
   input wire logic ctl_wr,
   // Host data bus
   input wire logic [7:0] host_wdata,
   output logic [7:0] host_rdata,
   output logic [7:0] host_rdata_oe,
   // Interrupt to host
   output logic irq_out,
   output logic irq_oe,
   // Drive state
   input wire logic write_gate_level_n,
   input wire logic xfer_request,
   input wire logic cmd_done,
   input wire logic cmd_error,
   // Decoded command to the drive engine
   output dhcp_pkg::dhcp_cmd_t cmd_code,
   output logic cmd_start,
   output logic retries_off,
   output logic long_mode,
   output logic spindle_run,
   output logic timeout_load,
   output logic drive_reset
);
   ////////////////////////////////////////////////////////////////////////////////
   dhcp_pkg::dhcp_state_t state_q;
   logic [7:0] err_q, scnt_q, snum_q, cyll_q, cylh_q, drvhd_q;
   logic [7:0] status;
   logic irq_pend_q, irq_dis_q, soft_reset_bit_q, err_flag_q, drq_q;
   logic [15:0] init_cnt_q;
   logic any_reset, cmd_wr, stat_rd, busy;
   dhcp_pkg::dhcp_cmd_t dec;

   // Decoding is shared between command start and the abort check
   function automatic dhcp_pkg::dhcp_cmd_t decode(input logic [7:0] op);
      if (op[7:4] == 4'h7) begin
         decode = dhcp_pkg::DHCP_CMD_SEEK;
      end else if (op[7:4] == 4'h1) begin
         // Recalibrate ignores the low nibble, as seek does
         decode = dhcp_pkg::DHCP_CMD_RECAL;
      end else begin
         case (op)
            8'h20, 8'h21, 8'h22, 8'h23: decode = dhcp_pkg::DHCP_CMD_READ;
            8'h30, 8'h31, 8'h32, 8'h33: decode = dhcp_pkg::DHCP_CMD_WRITE;
            8'h40, 8'h41: decode = dhcp_pkg::DHCP_CMD_READ_VERIFY;
            8'h3c: decode = dhcp_pkg::DHCP_CMD_WRITE_VERIFY;
            8'he4: decode = dhcp_pkg::DHCP_CMD_READ_BUF;
            8'he8: decode = dhcp_pkg::DHCP_CMD_WRITE_BUF;
            8'hc4: decode = dhcp_pkg::DHCP_CMD_READ_MULT;
            8'hc5: decode = dhcp_pkg::DHCP_CMD_WRITE_MULT;
            8'hc8, 8'hc9: decode = dhcp_pkg::DHCP_CMD_READ_DMA;
            8'hca, 8'hcb: decode = dhcp_pkg::DHCP_CMD_WRITE_DMA;
            8'hef: decode = dhcp_pkg::DHCP_CMD_SET_FEAT;
            8'hc6: decode = dhcp_pkg::DHCP_CMD_SET_MULT;
            8'hf8: decode = dhcp_pkg::DHCP_CMD_READ_MAX;
            8'hf9: decode = dhcp_pkg::DHCP_CMD_SET_MAX;
            8'h50: decode = dhcp_pkg::DHCP_CMD_FORMAT;
            8'h90: decode = dhcp_pkg::DHCP_CMD_DIAG;
            8'h94, 8'he0: decode = dhcp_pkg::DHCP_CMD_STBY_IMM;
            8'h95, 8'he1: decode = dhcp_pkg::DHCP_CMD_IDLE_IMM;
            8'h96, 8'he2: decode = dhcp_pkg::DHCP_CMD_STBY;
            8'h97, 8'he3: decode = dhcp_pkg::DHCP_CMD_IDLE;
            // Supported opcodes without a rule of their own still must not abort
            8'h98, 8'he5: decode = dhcp_pkg::DHCP_CMD_CHK_POWER;
            8'h99, 8'he6: decode = dhcp_pkg::DHCP_CMD_SLEEP;
            8'h91: decode = dhcp_pkg::DHCP_CMD_INIT_PARAMS;
            8'hec: decode = dhcp_pkg::DHCP_CMD_IDENTIFY;
            8'hb0: decode = dhcp_pkg::DHCP_CMD_HEALTH;
            default: decode = dhcp_pkg::DHCP_CMD_INVALID;
         endcase
      end
   endfunction

   // Opcode variant bits: bit 0 turns retries off, bit 1 selects long transfer
   function automatic logic has_retry_bit(input dhcp_pkg::dhcp_cmd_t c);
      has_retry_bit = (c == dhcp_pkg::DHCP_CMD_READ) || (c == dhcp_pkg::DHCP_CMD_WRITE) ||
         (c == dhcp_pkg::DHCP_CMD_READ_VERIFY) || (c == dhcp_pkg::DHCP_CMD_READ_DMA) ||
         (c == dhcp_pkg::DHCP_CMD_WRITE_DMA);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Strobes
   assign any_reset = !host_reset_n || soft_reset_bit_q;
   // A command written while busy is dropped; the host polls busy first
   assign cmd_wr = tf_cs && tf_wr && (tf_addr == `DHCP_TF_CMD) && !busy;
   assign stat_rd = tf_cs && tf_rd && (tf_addr == `DHCP_TF_CMD);
   assign busy = (state_q != dhcp_pkg::DHCP_ST_READY);
   assign dec = decode(host_wdata);

   // Fault bit stays 0: this port never sees a write fault
   always_comb begin
      status = 8'h00;
      status[`DHCP_ST_BUSY] = busy;
      status[`DHCP_ST_DRDY] = !busy;
      status[`DHCP_ST_DSC] = 1'b1;
      status[`DHCP_ST_DRQ] = drq_q;
      status[`DHCP_ST_ERR] = err_flag_q;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Device control register; disable bit powers up 0
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         soft_reset_bit_q <= 1'b0;
         irq_dis_q <= 1'b0;
      end else if (ctl_cs && ctl_wr && (ctl_addr == `DHCP_CTL_ALT)) begin
         soft_reset_bit_q <= host_wdata[`DHCP_DC_SOFT_RESET_BIT_BIT];
         irq_dis_q <= host_wdata[`DHCP_DC_IRQDIS_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Control state: reset, initialise, ready, executing
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_q <= dhcp_pkg::DHCP_ST_RESET;
         init_cnt_q <= 16'h0000;
      end else if (any_reset) begin
         state_q <= dhcp_pkg::DHCP_ST_RESET;
         init_cnt_q <= 16'h0000;
      end else begin
         case (state_q)
            dhcp_pkg::DHCP_ST_RESET: begin
               state_q <= dhcp_pkg::DHCP_ST_INIT;
            end
            dhcp_pkg::DHCP_ST_INIT: begin
               // Busy holds until initialisation count expires
               if (init_cnt_q == 16'(INIT_CYCLES - 1)) begin
                  state_q <= dhcp_pkg::DHCP_ST_READY;
               end else begin
                  init_cnt_q <= init_cnt_q + 16'h0001;
               end
            end
            dhcp_pkg::DHCP_ST_READY: begin
               if (cmd_wr && dec != dhcp_pkg::DHCP_CMD_INVALID) begin
                  state_q <= dhcp_pkg::DHCP_ST_EXEC;
               end
            end
            dhcp_pkg::DHCP_ST_EXEC: begin
               if (cmd_done) begin
                  state_q <= dhcp_pkg::DHCP_ST_READY;
               end
            end
            default: state_q <= dhcp_pkg::DHCP_ST_RESET;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Task file parameter registers
   always_ff @(posedge clk) begin
      if (!rst_n || any_reset) begin
         err_q <= `DHCP_RST_ERR;
         scnt_q <= `DHCP_RST_SCNT;
         snum_q <= `DHCP_RST_SNUM;
         cyll_q <= `DHCP_RST_CYL;
         cylh_q <= `DHCP_RST_CYL;
         drvhd_q <= `DHCP_RST_DRVHD;
      end else begin
         // Writes while busy are dropped so a running command keeps its operands
         if (tf_cs && tf_wr && !busy) begin
            if (tf_addr == `DHCP_TF_SCNT) begin
               scnt_q <= host_wdata;
            end else if (tf_addr == `DHCP_TF_SNUM) begin
               snum_q <= host_wdata;
            end else if (tf_addr == `DHCP_TF_CYLL) begin
               cyll_q <= host_wdata;
            end else if (tf_addr == `DHCP_TF_CYLH) begin
               cylh_q <= host_wdata;
            end else if (tf_addr == `DHCP_TF_DRVHD) begin
               drvhd_q <= host_wdata;
            end
         end
         if (cmd_wr && dec == dhcp_pkg::DHCP_CMD_INVALID) begin
            err_q <= 8'h01 << `DHCP_ER_ABRT;
         end else if (cmd_wr) begin
            err_q <= 8'h00;
         end else if (cmd_done && cmd_error && state_q == dhcp_pkg::DHCP_ST_EXEC) begin
            err_q <= 8'h01 << `DHCP_ER_ABRT;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Status flags: error and data request
   always_ff @(posedge clk) begin
      if (!rst_n || any_reset) begin
         err_flag_q <= 1'b0;
         drq_q <= 1'b0;
      end else begin
         if (cmd_wr) begin
            err_flag_q <= (dec == dhcp_pkg::DHCP_CMD_INVALID);
         end else if (cmd_done && state_q == dhcp_pkg::DHCP_ST_EXEC) begin
            err_flag_q <= cmd_error;
         end
         drq_q <= xfer_request && (state_q == dhcp_pkg::DHCP_ST_EXEC);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Pending interrupt; a new event wins over a status-read clear
   always_ff @(posedge clk) begin
      if (!rst_n || any_reset) begin
         irq_pend_q <= 1'b0;
      end else if (cmd_wr && dec == dhcp_pkg::DHCP_CMD_INVALID) begin
         irq_pend_q <= 1'b1;
      end else if (cmd_wr) begin
         irq_pend_q <= 1'b0;
      end else if (state_q == dhcp_pkg::DHCP_ST_EXEC && (cmd_done || (xfer_request && !drq_q))) begin
         irq_pend_q <= 1'b1;
      end else if (stat_rd) begin
         irq_pend_q <= 1'b0;
      end
   end

   // Pending state is kept while disabled and shows once enabled again
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         irq_out <= 1'b0;
         irq_oe <= 1'b0;
      end else begin
         irq_out <= irq_pend_q && !irq_dis_q;
         irq_oe <= !irq_dis_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read data path, registered one cycle after the strobe
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         host_rdata <= 8'h00;
         host_rdata_oe <= 8'h00;
      end else if (ctl_cs && ctl_rd && ctl_addr == `DHCP_CTL_ALT) begin
         host_rdata <= status;
         host_rdata_oe <= 8'hff;
      end else if (ctl_cs && ctl_rd && ctl_addr == `DHCP_CTL_DIN) begin
         host_rdata <= {1'b0, write_gate_level_n, ~drvhd_q[3:0],
            !drvhd_q[4], drvhd_q[4]};
         host_rdata_oe <= 8'h7f;
      end else if (tf_cs && tf_rd && tf_addr != `DHCP_TF_DATA) begin
         host_rdata_oe <= 8'hff;
         if (busy || tf_addr == `DHCP_TF_CMD) begin
            host_rdata <= status;
         end else if (tf_addr == `DHCP_TF_ERR) begin
            host_rdata <= err_q;
         end else if (tf_addr == `DHCP_TF_SCNT) begin
            host_rdata <= scnt_q;
         end else if (tf_addr == `DHCP_TF_SNUM) begin
            host_rdata <= snum_q;
         end else if (tf_addr == `DHCP_TF_CYLL) begin
            host_rdata <= cyll_q;
         end else if (tf_addr == `DHCP_TF_CYLH) begin
            host_rdata <= cylh_q;
         end else begin
            host_rdata <= drvhd_q;
         end
      end else begin
         host_rdata <= 8'h00;
         host_rdata_oe <= 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Command hand-off to the drive engine
   always_ff @(posedge clk) begin
      if (!rst_n || any_reset) begin
         cmd_code <= dhcp_pkg::DHCP_CMD_NONE;
         cmd_start <= 1'b0;
         retries_off <= 1'b0;
         long_mode <= 1'b0;
         timeout_load <= 1'b0;
      end else begin
         cmd_start <= cmd_wr && dec != dhcp_pkg::DHCP_CMD_INVALID;
         timeout_load <= 1'b0;
         if (cmd_wr && dec != dhcp_pkg::DHCP_CMD_INVALID) begin
            cmd_code <= dec;
            retries_off <= has_retry_bit(dec) && host_wdata[0];
            long_mode <= ((dec == dhcp_pkg::DHCP_CMD_READ) ||
               (dec == dhcp_pkg::DHCP_CMD_WRITE)) && host_wdata[1];
            timeout_load <= (dec == dhcp_pkg::DHCP_CMD_STBY) ||
               (dec == dhcp_pkg::DHCP_CMD_IDLE);
         end
      end
   end

   // Spindle keeps its state across soft reset; power-on and the standby opcodes stop it
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         spindle_run <= 1'b0;
         drive_reset <= 1'b1;
      end else begin
         drive_reset <= any_reset || state_q == dhcp_pkg::DHCP_ST_RESET;
         if (cmd_wr && (dec == dhcp_pkg::DHCP_CMD_STBY_IMM || dec == dhcp_pkg::DHCP_CMD_STBY)) begin
            spindle_run <= 1'b0;
         end else if (cmd_wr && (dec == dhcp_pkg::DHCP_CMD_IDLE_IMM ||
               dec == dhcp_pkg::DHCP_CMD_IDLE)) begin
            spindle_run <= 1'b1;
         end
      end
   end
endmodule

// ===== design/dhcp_pkg.sv
// Types of the host command and control port
package dhcp_pkg;
   typedef enum logic [4:0] {
      DHCP_CMD_NONE = 5'h00,
      DHCP_CMD_READ = 5'h01,
      DHCP_CMD_WRITE = 5'h02,
      DHCP_CMD_READ_VERIFY = 5'h03,
      DHCP_CMD_WRITE_VERIFY = 5'h04,
      DHCP_CMD_READ_BUF = 5'h05,
      DHCP_CMD_WRITE_BUF = 5'h06,
      DHCP_CMD_READ_MULT = 5'h07,
      DHCP_CMD_WRITE_MULT = 5'h08,
      DHCP_CMD_READ_DMA = 5'h09,
      DHCP_CMD_WRITE_DMA = 5'h0a,
      DHCP_CMD_SET_FEAT = 5'h0b,
      DHCP_CMD_SET_MULT = 5'h0c,
      DHCP_CMD_READ_MAX = 5'h0d,
      DHCP_CMD_SET_MAX = 5'h0e,
      DHCP_CMD_SEEK = 5'h0f,
      DHCP_CMD_FORMAT = 5'h10,
      DHCP_CMD_DIAG = 5'h11,
      DHCP_CMD_STBY_IMM = 5'h12,
      DHCP_CMD_IDLE_IMM = 5'h13,
      DHCP_CMD_STBY = 5'h14,
      DHCP_CMD_IDLE = 5'h15,
      DHCP_CMD_RECAL = 5'h16,
      DHCP_CMD_INIT_PARAMS = 5'h17,
      DHCP_CMD_IDENTIFY = 5'h18,
      DHCP_CMD_CHK_POWER = 5'h19,
      DHCP_CMD_SLEEP = 5'h1a,
      DHCP_CMD_HEALTH = 5'h1b,
      DHCP_CMD_INVALID = 5'h1f
   } dhcp_cmd_t;
   typedef enum logic [1:0] {
      DHCP_ST_RESET = 2'b00,
      DHCP_ST_INIT = 2'b01,
      DHCP_ST_READY = 2'b10,
      DHCP_ST_EXEC = 2'b11
   } dhcp_state_t;
endpackage

// ===== design/dhcp_regs.svh
// Register offsets, field positions, reset values and timing counts of the host port
`ifndef DHCP_REGS_SVH
`define DHCP_REGS_SVH
// Task file port offsets (three-bit register select)
`define DHCP_TF_DATA 3'h0
`define DHCP_TF_ERR 3'h1
`define DHCP_TF_SCNT 3'h2
`define DHCP_TF_SNUM 3'h3
`define DHCP_TF_CYLL 3'h4
`define DHCP_TF_CYLH 3'h5
`define DHCP_TF_DRVHD 3'h6
`define DHCP_TF_CMD 3'h7
// Control ports
`define DHCP_CTL_ALT 10'h3f6
`define DHCP_CTL_DIN 10'h3f7
// Device control fields
`define DHCP_DC_SOFT_RESET_BIT_BIT 2
`define DHCP_DC_IRQDIS_BIT 1
// Status fields
`define DHCP_ST_BUSY 7
`define DHCP_ST_DRDY 6
`define DHCP_ST_DSC 4
`define DHCP_ST_DRQ 3
`define DHCP_ST_ERR 0
// Error fields
`define DHCP_ER_ABRT 2
// Reset values
`define DHCP_RST_ERR 8'h01
`define DHCP_RST_SCNT 8'h01
`define DHCP_RST_SNUM 8'h01
`define DHCP_RST_CYL 8'h00
`define DHCP_RST_DRVHD 8'h00
// Timing
`define DHCP_CLK_MHZ 20
`define DHCP_INIT_TIME_US 2
`define DHCP_INIT_CYCLES (`DHCP_INIT_TIME_US * `DHCP_CLK_MHZ)
`endif

// ===== sim/dhcp_host_bfm.sv
// Host controller model: one-cycle register strobes on the parallel port
`timescale 1ns/1ps
module dhcp_host_bfm (
   input wire logic clk,
   output logic tf_cs = 0,
   output logic [2:0] tf_addr = 3'h0,
   output logic tf_rd = 0,
   output logic tf_wr = 0,
   output logic ctl_cs = 0,
   output logic [9:0] ctl_addr = 10'h000,
   output logic ctl_rd = 0,
   output logic ctl_wr = 0,
   output logic [7:0] host_wdata = 8'h00
);
   // Parameters go first, opcode last: the caller orders the accesses
   // Soft reset hold time is counted by the caller between two writes
   task automatic acc(input bit c, input bit w, input logic [9:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      {ctl_cs, ctl_rd, ctl_wr} = {c, c & !w, c & w};
      {tf_cs, tf_rd, tf_wr} = {!c, !c & !w, !c & w};
      ctl_addr = a;
      tf_addr = a[2:0];
      host_wdata = d;
      @(posedge clk);
      #1;
      {ctl_cs, ctl_rd, ctl_wr, tf_cs, tf_rd, tf_wr} = 6'h00;
      // Released lines do not keep their last value
      ctl_addr = ~a;
      tf_addr = ~a[2:0];
      host_wdata = ~d;
   endtask
endmodule

// ===== sim/dhcp_host_port_chk.sv
// Port-level assertions of the host command and control port
`timescale 1ns/1ps
module dhcp_host_port_chk #(
   parameter int INIT_CYCLES = 8
) (
   // Clock and resets
   input wire logic clk,
   input wire logic rst_n,
   input wire logic host_reset_n,
   // Host accesses and drive state inputs
   input wire logic tf_cs,
   input wire logic [2:0] tf_addr,
   input wire logic tf_rd,
   input wire logic tf_wr,
   input wire logic ctl_cs,
   input wire logic [9:0] ctl_addr,
   input wire logic ctl_rd,
   input wire logic ctl_wr,
   input wire logic [7:0] host_wdata,
   input wire logic write_gate_level_n,
   input wire logic xfer_request,
   input wire logic cmd_done,
   // Outputs watched
   input wire logic [7:0] host_rdata,
   input wire logic [7:0] host_rdata_oe,
   input wire logic irq_out,
   input wire logic irq_oe,
   input wire logic cmd_start,
   input wire logic timeout_load,
   input wire logic drive_reset
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic cmd_wr, st_rd, c_wr, c_rd;
   assign cmd_wr = tf_cs && tf_wr && tf_addr == 3'h7;
   assign st_rd = tf_cs && tf_rd && tf_addr == 3'h7;
   assign c_wr = ctl_cs && ctl_wr && ctl_addr == 10'h3f6;
   assign c_rd = ctl_cs && ctl_rd;
   ////////////////////////////////////////////////////////////////////////////////
   property p_cmd_irq; cmd_start |=> !irq_out; endproperty
   a_cmd_irq: assert property (p_cmd_irq) else $error("irq kept after command write");
   // A new event beats the clear, so reads during events are left out
   property p_stat_clr; st_rd && !cmd_done && !xfer_request |-> ##2 !irq_out; endproperty
   a_stat_clr: assert property (p_stat_clr) else $error("irq kept after status read");
   property p_alt_keep; irq_out && c_rd && !tf_cs && host_reset_n |=> irq_out; endproperty
   a_alt_keep: assert property (p_alt_keep) else $error("control read cleared irq");
   property p_irq_dis; c_wr |-> ##2 irq_oe == !$past(host_wdata[1], 2); endproperty
   a_irq_dis: assert property (p_irq_dis) else $error("irq enable wrong");
   property p_irq_gate; !irq_oe |-> !irq_out; endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("irq driven while disabled");
   property p_soft_reset_bit; c_wr && host_wdata[2] |-> ##2 drive_reset; endproperty
   a_soft_reset_bit: assert property (p_soft_reset_bit) else $error("soft reset not taken");
   property p_hrst; !host_reset_n |-> ##1 drive_reset ##1 !irq_out; endproperty
   a_hrst: assert property (p_hrst) else $error("hardware reset not taken");
   property p_init; $fell(drive_reset) |-> !irq_out [*4]; endproperty
   a_init: assert property (p_init) else $error("irq at reset completion");
   property p_din;
      c_rd && ctl_addr == 10'h3f7 && !drive_reset |=>
         host_rdata_oe == 8'h7f && host_rdata[6] == $past(write_gate_level_n);
   endproperty
   a_din: assert property (p_din) else $error("digital input read wrong");
   property p_quiet; !(tf_cs && tf_rd) && !c_rd |=> host_rdata == 8'h00; endproperty
   a_quiet: assert property (p_quiet) else $error("read data without read");
   property p_start; cmd_start |=> !cmd_start && !timeout_load [*2]; endproperty
   a_start: assert property (p_start) else $error("start pulse too long");
   c_cmd: cover property (cmd_start);
   c_irq: cover property ($rose(irq_out));
   c_rst: cover property ($fell(drive_reset));
   c_bad: cover property (cmd_wr ##1 !cmd_start);
endmodule
bind dhcp_host_port dhcp_host_port_chk #(.INIT_CYCLES(INIT_CYCLES)) i_chk (
   .clk(clk), .rst_n(rst_n), .host_reset_n(host_reset_n), .tf_cs(tf_cs),
   .tf_addr(tf_addr), .tf_rd(tf_rd), .tf_wr(tf_wr), .ctl_cs(ctl_cs),
   .ctl_addr(ctl_addr), .ctl_rd(ctl_rd), .ctl_wr(ctl_wr), .host_wdata(host_wdata),
   .write_gate_level_n(write_gate_level_n), .xfer_request(xfer_request),
   .cmd_done(cmd_done), .host_rdata(host_rdata), .host_rdata_oe(host_rdata_oe),
   .irq_out(irq_out), .irq_oe(irq_oe), .cmd_start(cmd_start),
   .timeout_load(timeout_load), .drive_reset(drive_reset));

// ===== sim/dhcp_host_port_tb.sv
// Self-checking bench of the host command and control port
`timescale 1ns/1ps
module dhcp_host_port_tb;
   logic clk = 0, rst_n = 0, host_reset_n = 1, write_gate_level_n = 1;
   logic xfer_request = 0, cmd_done = 0, rdp = 0;
   logic tf_cs, tf_rd, tf_wr, ctl_cs, ctl_rd, ctl_wr;
   logic [2:0] tf_addr;
   logic [9:0] ctl_addr;
   logic [7:0] host_wdata, host_rdata, host_rdata_oe, dh;
   logic irq_out, irq_oe, cmd_start, retries_off, long_mode, spindle_run;
   logic timeout_load, drive_reset;
   dhcp_pkg::dhcp_cmd_t cmd_code;
   logic [15:0] rq[$], cq[$], e;
   int num_errors = 0, num_checks = 0, cycles = 0, tl_cnt = 0, seed = 32'h077f;
   logic [15:0] tbl [0:44] = '{16'h2001, 16'h2101, 16'h2201, 16'h2301, 16'h3002,
      16'h3102, 16'h3202, 16'h3302, 16'h4003, 16'h4103, 16'h3c04, 16'he405, 16'he806,
      16'hc407, 16'hc508, 16'hc809, 16'hc909, 16'hca0a, 16'hcb0a, 16'hef0b, 16'hc60c,
      16'hf80d, 16'hf90e, 16'h700f, 16'h5010, 16'h9011, 16'h9412, 16'he012, 16'h9513,
      16'he113, 16'h9614, 16'he214, 16'h9715, 16'he315, 16'hff1f, 16'hec18, 16'h1016,
      16'h9117, 16'h9819, 16'he519, 16'h991a, 16'he61a, 16'hb01b, 16'h001f, 16'ha01f};
   initial forever #25 clk = ~clk;
   dhcp_host_bfm h (.clk(clk), .tf_cs(tf_cs), .tf_addr(tf_addr), .tf_rd(tf_rd),
      .tf_wr(tf_wr), .ctl_cs(ctl_cs), .ctl_addr(ctl_addr), .ctl_rd(ctl_rd),
      .ctl_wr(ctl_wr), .host_wdata(host_wdata));
   dhcp_host_port #(.INIT_CYCLES(8)) i_dut (.clk(clk), .rst_n(rst_n),
      .host_reset_n(host_reset_n), .tf_cs(tf_cs), .tf_addr(tf_addr), .tf_rd(tf_rd),
      .tf_wr(tf_wr), .ctl_cs(ctl_cs), .ctl_addr(ctl_addr), .ctl_rd(ctl_rd),
      .ctl_wr(ctl_wr), .host_wdata(host_wdata), .host_rdata(host_rdata),
      .host_rdata_oe(host_rdata_oe), .irq_out(irq_out), .irq_oe(irq_oe),
      .write_gate_level_n(write_gate_level_n), .xfer_request(xfer_request),
      .cmd_done(cmd_done), .cmd_error(1'b0), .cmd_code(cmd_code), .cmd_start(cmd_start),
      .retries_off(retries_off), .long_mode(long_mode), .spindle_run(spindle_run),
      .timeout_load(timeout_load), .drive_reset(drive_reset));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] g, input logic [15:0] x, input string m);
      num_checks++;
      if (g !== x) begin
         num_errors++;
         $display("wrong value at %0t: %s got %h expected %h", $time, m, g, x);
      end
   endtask
   task automatic chk1(input logic g, input logic x, input string m);
      chk({15'h0, g}, {15'h0, x}, m);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic rx(input bit c, input logic [9:0] a, input logic [15:0] x);
      rq.push_back(x);
      h.acc(c, 0, a, 8'h00);
   endtask
   task automatic wx(input bit c, input logic [9:0] a, input logic [7:0] d);
      h.acc(c, 1, a, d);
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Reads and decoded commands are compared against the oldest note
   always @(posedge clk) begin
      rdp <= (tf_cs & tf_rd) | (ctl_cs & ctl_rd);
      cycles++;
      if (timeout_load === 1'b1) tl_cnt++;
      if (cycles == 20000) begin
         num_errors++;
         close_out;
      end
   end
   always @(negedge clk) begin
      if (rdp) begin
         e = rq.size() ? rq.pop_front() : 16'hxxxx;
         chk({host_rdata_oe, host_rdata & host_rdata_oe}, e, "read");
      end
      if (cmd_start === 1'b1) begin
         e = cq.size() ? cq.pop_front() : 16'hxxxx;
         chk({3'h0, cmd_code, 6'h0, e[15:13] == 3'h1 ? {retries_off, long_mode} : 2'h0},
            {3'h0, e[4:0], 6'h0, e[15:13] == 3'h1 ? {e[8], e[9]} : 2'h0}, "decode");
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic after_rst;
      rx(0, 4, 16'hff90);
      cyc(12);
      chk1(irq_out, 0, "irq after reset");
      chk1(irq_oe, 1, "irq enable");
      for (int i = 1; i < 7; i++) rx(0, i, {8'hff, i < 4 ? 8'h01 : 8'h00});
      rx(1, 10'h3f7, {9'h0fe, write_gate_level_n, 6'h3e});
      rx(1, 10'h3f6, 16'hff50);
   endtask
   task automatic run_cmd(input logic [15:0] t);
      tl_cnt = 0;
      wx(0, 2, $random(seed));
      cq.push_back(t);
      wx(0, 7, t[15:8]);
      rx(0, 7, 16'hff90);
      chk1(irq_out, 0, "irq withdrawn");
      xfer_request = 1;
      cyc(3);
      chk1(irq_out, 1, "transfer irq");
      xfer_request = 0;
      rx(0, 7, 16'hff90);
      cmd_done = 1;
      cyc(1);
      cmd_done = 0;
      cyc(3);
      chk1(irq_out, 1, "done irq");
      rx(0, 7, 16'hff50);
      cyc(3);
      chk1(irq_out, 0, "irq cleared");
      if (t[4:0] >= 5'h12 && t[4:0] <= 5'h15) begin
         chk1(spindle_run, t[0], "spindle");
         chk1(tl_cnt == 1, t[4:0] > 5'h13, "timeout load");
      end
   endtask
   task automatic bad_cmd(input logic [7:0] op, input bit en);
      wx(0, 7, op);
      cyc(3);
      chk1(irq_out, en, "abort irq");
      rx(1, 10'h3f6, 16'hff51);
      chk1(irq_out, en, "irq kept");
      rx(0, 1, 16'hff04);
   endtask
   initial begin
      repeat (6) @(posedge clk);
      #1;
      rst_n = 1;
      after_rst;
      $display("test power-on reset done");
      foreach (tbl[i]) begin
         if (tbl[i][4:0] == 5'h0f || tbl[i][4:0] == 5'h16) tbl[i][11:8] = $random(seed);
         if (tbl[i][4:0] == 5'h1f) begin
            bad_cmd(tbl[i][15:8], 1);
            rx(0, 7, 16'hff51);
         end else run_cmd(tbl[i]);
      end
      $display("test decode done");
      wx(1, 10'h3f6, 8'h02);
      cyc(1);
      chk1(irq_oe, 0, "irq tri-state");
      bad_cmd(8'hff, 0);
      wx(1, 10'h3f6, 8'h00);
      cyc(3);
      chk1(irq_out, 1, "held irq shows");
      run_cmd(tbl[8]);
      $display("test irq disable done");
      for (int k = 0; k < 2; k++) begin
         dh = $random(seed);
         write_gate_level_n = $random(seed);
         for (int i = 3; i < 7; i++) wx(0, i, dh);
         rx(1, 10'h3f7, {9'h0fe, write_gate_level_n, ~dh[3:0], ~dh[4], dh[4]});
         if (k == 0) begin
            host_reset_n = 0;
            cyc(3);
            chk1(drive_reset, 1, "hardware reset");
            host_reset_n = 1;
         end else begin
            wx(1, 10'h3f6, 8'h04);
            cyc(1);
            chk1(drive_reset, 1, "soft reset");
            cyc(100);
            chk1(drive_reset, 1, "soft reset held");
            wx(1, 10'h3f6, 8'h00);
         end
         after_rst;
         $display("test reset kind %0d done", k);
      end
      cyc(4);
      chk1(rq.size() + cq.size() == 0, 1, "notes left");
      close_out;
   end
endmodule
